// [shared/xio_defs.vh]
// constants for the extra i/o port: register map, fields, resets, limits
`ifndef XIO_DEFS_VH
`define XIO_DEFS_VH

// register indices as printed (not all multiples of four)
`define XIO_REG_DIRECTION 16'hb7fc
`define XIO_REG_DATA      16'hb806
`define XIO_REG_LEVEL0    16'hb810
`define XIO_REG_LEVEL1    16'hb811
`define XIO_REG_LEVEL2    16'hb812
`define XIO_REG_LEVEL3    16'hb813
`define XIO_REG_UPDATE    16'hb81a

// direction field: one bit per eight-line group
`define XIO_DIR_BITS      3
`define XIO_DIR_RESET     3'h0
`define XIO_LINES         24
`define XIO_GROUP_W       8

// analog limits in millivolts, converter and update values, level and data resets
`define XIO_MV_MAX        32'sd10000
`define XIO_MV_MIN        (-32'sd10000)
`define XIO_MV_STEP       32'sd5
`define XIO_LEVEL_RESET   32'h0000_0000
`define XIO_DAC_MID       12'h800
`define XIO_DAC_W         12
`define XIO_UPDATE_GO     32'h0000_0001
`define XIO_DATA_RESET    24'h00_0000

`endif

// [rtl/xio_dac_code.v]
// millivolt level to 12-bit offset-binary converter code
`timescale 1ns/1ps
`include "xio_defs.vh"

module xio_dac_code (
  input  wire [31:0] level_mv, // signed millivolt setting
  output wire [11:0] code      // converter code, 0x800 at 0 mV
);
  wire signed [31:0] mv_s;
  wire signed [31:0] clamped;
  wire signed [31:0] steps;
  wire signed [31:0] biased;

  assign mv_s = level_mv;
  // out-of-range levels clamp to the nearest limit
  assign clamped = (mv_s > `XIO_MV_MAX) ? `XIO_MV_MAX :
                   (mv_s < `XIO_MV_MIN) ? `XIO_MV_MIN : mv_s;
  // 5 mV per step; 10000 mV is 2000 steps, inside +-2047
  assign steps  = clamped / `XIO_MV_STEP;
  assign biased = steps + $signed({20'h0_0000, `XIO_DAC_MID});
  assign code   = biased[11:0];
endmodule // xio_dac_code

// [rtl/xio_line_group.v]
// one eight-line digital group: direction, output latch and pin drive
`timescale 1ns/1ps
`include "xio_defs.vh"

module xio_line_group (
  input  wire       clk,     // register clock
  input  wire       resetn,  // async reset, active low
  input  wire       is_out,  // group direction, 1 = output
  input  wire       wr,      // data register write strobe
  input  wire [7:0] wdata,   // written byte for this group
  input  wire [7:0] pin_in,  // pin levels
  output reg  [7:0] pin_out, // driven pattern
  output wire [7:0] pin_oe,  // output enable, high while driving
  output wire [7:0] level    // live pin level for read back
);
  // only output groups take written data
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_out <= 8'h00;
    end else if (wr && is_out) begin
      pin_out <= wdata;
    end
  end

  assign pin_oe = {8{is_out}};
  // read back the pin itself, so outputs show the driven pattern
  assign level  = pin_in;
endmodule // xio_line_group

// [rtl/xio_port.v]
// extra i/o port: digital groups, data register, four analog levels
`timescale 1ns/1ps
`include "xio_defs.vh"

// How it works
// - a group is output when its direction bit is one, else input.
// - one direction write sets all groups, each from its own bit.
// - group 0 is lines 7..0, group 1 is 15..8, group 2 is 23..16.
// - the internal-header variant has only 16 lines and two groups.
// - one 32-bit data register, bit n is line n.
// - reading data returns live pin levels, outputs included.
// - writes to data bits 31..24 are discarded.
// - a data write changes only groups set as outputs.
// - each level becomes a 12-bit converter code.
// - reading a level returns the stored programmed value.
// - writing 1 to the update register loads all four codes at once.
// - lines change only through register accesses or a reset, nothing else.
module xio_port #(
  parameter HEADER_VARIANT = 0 // 1 = internal header, 16 lines
) (
  input  wire        clk,      // register clock
  input  wire        resetn,   // async reset, active low
  input  wire [15:0] reg_addr, // register index
  input  wire        reg_wr,   // write strobe, one cycle
  input  wire        reg_rd,   // read strobe, one cycle
  input  wire [31:0] reg_wdata,// write data
  output reg  [31:0] reg_rdata,// read data, valid cycle after reg_rd
  output reg         reg_ack,  // access taken, one cycle after strobe
  input  wire [23:0] line_in,  // digital pin levels
  output wire [23:0] line_out, // digital pin drive value
  output wire [23:0] line_oe,  // digital output enables
  output reg  [11:0] dac0,     // converter code, output A0
  output reg  [11:0] dac1,     // converter code, output A1
  output reg  [11:0] dac2,     // converter code, output A2
  output reg  [11:0] dac3,     // converter code, output A3
  output reg         dac_load  // pulse when codes change together
);
  localparam NGROUPS = (HEADER_VARIANT != 0) ? 2 : 3;

  reg  [2:0]  line_direction;
  reg  [31:0] analog_level_0;
  reg  [31:0] analog_level_1;
  reg  [31:0] analog_level_2;
  reg  [31:0] analog_level_3;
  wire [23:0] live;
  wire [11:0] code0;
  wire [11:0] code1;
  wire [11:0] code2;
  wire [11:0] code3;
  wire        hit_dir;
  wire        hit_data;
  wire        hit_upd;

  assign hit_dir  = (reg_addr == `XIO_REG_DIRECTION);
  assign hit_data = (reg_addr == `XIO_REG_DATA);
  assign hit_upd  = (reg_addr == `XIO_REG_UPDATE);

  // direction: all group bits taken in one write
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      line_direction <= `XIO_DIR_RESET;
    end else if (reg_wr && hit_dir) begin
      line_direction <= reg_wdata[2:0];
    end
  end

  // per-group logic; group g owns lines 8g+7..8g
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : grp
      if (g < NGROUPS) begin : present
        xio_line_group u_grp (
          .clk     (clk),
          .resetn  (resetn),
          .is_out  (line_direction[g]),
          .wr      (reg_wr && hit_data),
          .wdata   (reg_wdata[g*8 +: 8]),
          .pin_in  (line_in[g*8 +: 8]),
          .pin_out (line_out[g*8 +: 8]),
          .pin_oe  (line_oe[g*8 +: 8]),
          .level   (live[g*8 +: 8])
        );
      end else begin : absent
        // missing group on the header variant: never driven
        assign line_out[g*8 +: 8] = 8'h00;
        assign line_oe[g*8 +: 8]  = 8'h00;
        assign live[g*8 +: 8]     = 8'h00;
      end
    end
  endgenerate

  // programmed levels; outputs stay put until the update strobe
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      analog_level_0 <= `XIO_LEVEL_RESET;
      analog_level_1 <= `XIO_LEVEL_RESET;
      analog_level_2 <= `XIO_LEVEL_RESET;
      analog_level_3 <= `XIO_LEVEL_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `XIO_REG_LEVEL0) analog_level_0 <= reg_wdata;
      if (reg_addr == `XIO_REG_LEVEL1) analog_level_1 <= reg_wdata;
      if (reg_addr == `XIO_REG_LEVEL2) analog_level_2 <= reg_wdata;
      if (reg_addr == `XIO_REG_LEVEL3) analog_level_3 <= reg_wdata;
    end
  end

  xio_dac_code u_code0 (.level_mv (analog_level_0), .code (code0));
  xio_dac_code u_code1 (.level_mv (analog_level_1), .code (code1));
  xio_dac_code u_code2 (.level_mv (analog_level_2), .code (code2));
  xio_dac_code u_code3 (.level_mv (analog_level_3), .code (code3));

  // simultaneous load of all four codes on a write of exactly 1
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dac0     <= `XIO_DAC_MID;
      dac1     <= `XIO_DAC_MID;
      dac2     <= `XIO_DAC_MID;
      dac3     <= `XIO_DAC_MID;
      dac_load <= 1'b0;
    end else begin
      dac_load <= 1'b0;
      if (reg_wr && hit_upd && reg_wdata == `XIO_UPDATE_GO) begin
        dac0     <= code0;
        dac1     <= code1;
        dac2     <= code2;
        dac3     <= code3;
        dac_load <= 1'b1;
      end
    end
  end

  // read mux; top data byte reads zero, writes to it go nowhere
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
      reg_ack   <= 1'b0;
    end else begin
      reg_ack <= reg_rd | reg_wr;
      if (reg_rd) begin
        case (reg_addr)
          `XIO_REG_DIRECTION: reg_rdata <= {29'h0, line_direction};
          `XIO_REG_DATA:      reg_rdata <= {8'h00, live};
          `XIO_REG_LEVEL0:    reg_rdata <= analog_level_0;
          `XIO_REG_LEVEL1:    reg_rdata <= analog_level_1;
          `XIO_REG_LEVEL2:    reg_rdata <= analog_level_2;
          `XIO_REG_LEVEL3:    reg_rdata <= analog_level_3;
          default:            reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // xio_port

// [test/xio_port_monitor.sv]
// assertion checker for the extra i/o port
`timescale 1ns/1ps
`include "xio_defs.vh"
module xio_port_monitor #(
  parameter HEADER_VARIANT = 0 // 1 = internal header, 16 lines
) (
  input wire        clk,       // clock
  input wire        resetn,    // reset
  input wire [15:0] reg_addr,  // index
  input wire        reg_wr,    // write
  input wire        reg_rd,    // read
  input wire [31:0] reg_wdata, // wdata
  input wire [31:0] reg_rdata, // rdata
  input wire [23:0] line_in,   // pins
  input wire [23:0] line_out,  // drive
  input wire [23:0] line_oe,   // enables
  input wire [11:0] dac0,      // code a0
  input wire [11:0] dac1,      // code a1
  input wire [11:0] dac2,      // code a2
  input wire [11:0] dac3,      // code a3
  input wire        dac_load   // load pulse
);
  // lines that exist on this variant; group 2 is gone on the header one
  localparam [23:0] LINE_MASK = (HEADER_VARIANT != 0) ? 24'h00_ffff :
                                                        24'hff_ffff;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // decodes shared by the properties
  wire wr_dir = reg_wr && reg_addr == `XIO_REG_DIRECTION;
  wire wr_dat = reg_wr && reg_addr == `XIO_REG_DATA;
  wire wr_upd = reg_wr && reg_addr == `XIO_REG_UPDATE;
  wire go_upd = wr_upd && reg_wdata == `XIO_UPDATE_GO;
  chk_dir_groups: assert property (wr_dir |=> line_oe == (LINE_MASK & {
    {8{$past(reg_wdata[2])}},{8{$past(reg_wdata[1])}},
    {8{$past(reg_wdata[0])}}}))
    else $error("group enables wrong");
  chk_out_bytes: assert property (wr_dat |=>
    ((line_out ^ $past(reg_wdata[23:0])) & line_oe) == 0) else $error("out");
  chk_in_bytes: assert property (wr_dat |=>
    ((line_out ^ $past(line_out)) & ~line_oe) == 0) else $error("in");
  chk_read_live: assert property (reg_rd && reg_addr == `XIO_REG_DATA |=>
    reg_rdata == {8'h00, $past(line_in) & LINE_MASK}) else $error("read back");
  chk_lines_quiet: assert property (!reg_wr |=>
    $stable(line_out) && $stable(line_oe)) else $error("lines moved");
  chk_dac_hold: assert property (!go_upd |=>
    $stable({dac0, dac1, dac2, dac3})) else $error("dac moved");
  chk_update_load: assert property (go_upd |=> dac_load)
    else $error("no load");
  chk_load_cause: assert property (dac_load |-> $past(go_upd))
    else $error("stray load");
endmodule // xio_port_monitor

bind xio_port xio_port_monitor #(.HEADER_VARIANT(HEADER_VARIANT))
  u_mon (.clk(clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .line_in(line_in),
  .line_out(line_out), .line_oe(line_oe), .dac0(dac0), .dac1(dac1),
  .dac2(dac2), .dac3(dac3), .dac_load(dac_load));

// [test/xio_instr.sv]
// far side: instruments on the digital lines
`timescale 1ns/1ps
module xio_instr (
  input  wire [23:0] line_out, // port drive
  input  wire [23:0] line_oe,  // port enables
  input  wire [23:0] ext_val,  // instrument levels
  output wire [23:0] line_in   // resolved wire
);
  // port wins where it drives, instrument elsewhere
  assign line_in = (line_out & line_oe) | (ext_val & ~line_oe);
endmodule // xio_instr

// [test/testbench.sv]
// self-checking bench for the extra i/o port
`timescale 1ns/1ps
`include "xio_defs.vh"
module testbench;
  reg         clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
  reg  [15:0] reg_addr = 0;
  reg  [31:0] reg_wdata = 0;
  reg  [23:0] ext_val = 24'hc3c3c3;
  wire [31:0] reg_rdata;
  wire        reg_ack, dac_load;
  wire [23:0] line_in, line_out, line_oe;
  wire [11:0] dac0, dac1, dac2, dac3;
  wire [47:0] dacs = {dac0, dac1, dac2, dac3};
  // second port built as the 16-line header variant
  wire [31:0] rdata_h;
  wire [23:0] in_h, out_h, oe_h;
  integer     n_fail = 0, checks = 0, cyc = 0, i;
  always #20 clk = ~clk;
  xio_port dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe), .dac0(dac0), .dac1(dac1),
    .dac2(dac2), .dac3(dac3), .dac_load(dac_load));
  xio_instr far (.line_out(line_out), .line_oe(line_oe),
    .ext_val(ext_val), .line_in(line_in));
  xio_port #(.HEADER_VARIANT(1)) dut_hdr (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(rdata_h), .reg_ack(),
    .line_in(in_h), .line_out(out_h), .line_oe(oe_h), .dac0(), .dac1(),
    .dac2(), .dac3(), .dac_load());
  xio_instr far_hdr (.line_out(out_h), .line_oe(oe_h),
    .ext_val(ext_val), .line_in(in_h));
  task chk(input [47:0] got, input [47:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // strobes rise and fall on falling edges, ack seen a cycle on
  task wr(input [15:0] a, input [31:0] d);
    begin
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      @(negedge clk);
      reg_wr = 0;
      chk(reg_ack, 1);
    end
  endtask
  task rd(input [15:0] a, input [31:0] e);
    begin
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1;
      @(negedge clk);
      reg_rd = 0;
      chk(reg_rdata, e);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // hang guard, far above the 82 or so cycles needed
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      summarize;
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    resetn = 1;
    rd(`XIO_REG_DIRECTION, 0);
    rd(`XIO_REG_LEVEL0, 0);
    chk(dacs, 48'h800800800800);
    chk(line_oe, 0);
    for (i = 0; i < 8; i = i + 1) begin
      wr(`XIO_REG_DIRECTION, i);
      chk(line_oe, {{8{i[2]}}, {8{i[1]}}, {8{i[0]}}});
      chk(oe_h, {8'h00, {8{i[1]}}, {8{i[0]}}});
      rd(`XIO_REG_DIRECTION, i);
    end
    wr(`XIO_REG_DIRECTION, 5);
    wr(`XIO_REG_DATA, 32'hff5a3c96);
    chk(line_out, 24'h5a0096);
    chk(oe_h, 24'h0000ff);
    chk(out_h, 24'h000096);
    rd(`XIO_REG_DATA, 32'h005ac396);
    chk(rdata_h, 32'h0000c396);
    wr(`XIO_REG_DIRECTION, 2);
    wr(`XIO_REG_DATA, 32'h00112233);
    rd(`XIO_REG_DATA, 32'h00c322c3);
    wr(`XIO_REG_LEVEL0, -2000);
    wr(`XIO_REG_LEVEL1, 0);
    wr(`XIO_REG_LEVEL2, 3500);
    wr(`XIO_REG_LEVEL3, 10000);
    chk(dacs, 48'h800800800800);
    rd(`XIO_REG_LEVEL0, -2000);
    rd(`XIO_REG_LEVEL2, 3500);
    wr(`XIO_REG_UPDATE, 2);
    chk(dac_load, 0);
    chk(dacs, 48'h800800800800);
    wr(`XIO_REG_UPDATE, 1);
    chk(dac_load, 1);
    chk(dacs, 48'h670800abcfd0);
    wr(`XIO_REG_LEVEL0, 12000);
    wr(`XIO_REG_LEVEL1, -15000);
    wr(`XIO_REG_UPDATE, 1);
    chk(dacs, 48'hfd0030abcfd0);
    // reset in mid-run must bring every setting back
    @(negedge clk) resetn = 0;
    @(negedge clk) resetn = 1;
    chk(line_oe, 0);
    chk(line_out, 0);
    chk(dacs, 48'h800800800800);
    rd(`XIO_REG_LEVEL3, 0);
    rd(`XIO_REG_DIRECTION, 0);
    rd(16'hb800, 0);
    summarize;
  end
endmodule // testbench
